// *** design/int_ctrl_defs.vh ***
`ifndef INT_CTRL_DEFS_VH
`define INT_CTRL_DEFS_VH

// register offsets
`define OFF_EXT_FLAGS_A     8'hA3
`define OFF_EXT_FLAGS_B     8'hA4
`define OFF_EXT_FLAGS_C     8'hA5
`define OFF_EDGE_A_LOW      8'hA6
`define OFF_EDGE_A_HIGH     8'hA7
`define OFF_SRC_EN_0        8'hA8
`define OFF_SRC_EN_1        8'hA9
`define OFF_SRC_EN_2        8'hAA
`define OFF_SRC_EN_3        8'hAB
`define OFF_EDGE_B          8'hAD
`define OFF_EDGE_C_LOW      8'hAE
`define OFF_EDGE_C_HIGH     8'hAF
`define OFF_LEVEL_LOW       8'hB8
`define OFF_LEVEL_HIGH      8'hF8
`define OFF_PENDING_0       8'hC0
`define OFF_PENDING_1       8'hC1
`define OFF_PENDING_2       8'hC2
`define OFF_IN_SERVICE      8'hC3

// reset values and fields
`define RESET_BYTE          8'h00
`define GLOBAL_EN_BIT       7
`define EN_MASK_0           8'hBF
`define EN_MASK_6           8'h3F
`define EN_MASK_5           8'h1F
`define FLAGS_B_MASK        8'h07

// source numbering
`define NUM_SRC             24
`define NUM_GROUPS          5'd6
`define SRC_EXT_A           5'd5
`define SRC_EXT_B           5'd16
`define SRC_EXT_C           5'd23
`define NUM_PINS            19

// vector layout
`define VEC_BASE            16'h0003
`define VEC_STEP_SHIFT      3

// edge select codes
`define EDGE_NONE           2'b00
`define EDGE_RISE           2'b01
`define EDGE_FALL           2'b10
`define EDGE_BOTH           2'b11

`endif

// *** design/vectored_priority_interrupt_controller.v ***
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`include "int_ctrl_defs.vh"

// Overview of operation
// R1: serviced source long-calls to 0003H plus 8*n
// R2: service needs global enable and source enable
// R3: request flag sets, holds, clears on service
// R4: pending held until serviced, reset or write
// R5: accept only at instruction last cycle
// R6: hand vector; entry three to nine cycles
// R7: sample at last cycle, ack next first
// R8: return instruction ends current level service
// R9: higher level wins among simultaneous requests
// R10: preempt only by strictly higher level
// R11: equal level: lower source number first
// R12: 24 sources in 6 groups, four levels
// R13: level 3 highest; level registers reset zero
// R14: any enabled source raises wake release
// R15: postpone accept during control register writes
// R16: external pins gathered into sources 5, 16, 23
// R17: pin flags set on edge, cleared on service
// R18: edge select rising, falling, both; reset none
// R19: edge code 00 none,01 rise,10 fall,11 both
// R20: level bit from high register is msb
// R21: global enable clears on vector, sets on return
// R22: group k holds sources k,k+6,k+12,k+18
// R23: pins synchronised before edge detection
module vectored_priority_interrupt_controller (
    input  wire        clk_sys_i,
    input  wire        reset_i,
    input  wire [7:0]  reg_addr_i,
    input  wire [7:0]  reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output reg  [7:0]  reg_rdata_o,
    input  wire [23:0] irq_req_i,
    input  wire [18:0] ext_pin_i,
    input  wire        power_control_wr_i,
    input  wire        last_cycle_i,
    input  wire        ack_i,
    input  wire        return_i,
    output wire        irq_o,
    output reg  [15:0] vector_o,
    output reg  [4:0]  vector_src_o,
    output reg  [7:0]  vector_low_byte_o,
    output wire        wake_release_o
);

// =====================================================================
// functions
// =====================================================================
function [1:0] src_level;
    input [4:0] src;
    input [5:0] low_bits;
    input [5:0] high_bits;
    reg   [4:0] rem;
    reg   [2:0] grp;
    begin
        rem       = src % `NUM_GROUPS;                               // [R22]
        grp       = rem[2:0];
        src_level = {high_bits[grp], low_bits[grp]};                 // [R20] [R12]
    end
endfunction

function edge_hit;
    input [1:0] sel;
    input       prev;
    input       cur;
    begin
        case (sel)                                                   // [R19]
            `EDGE_RISE: edge_hit = ~prev & cur;
            `EDGE_FALL: edge_hit = prev & ~cur;
            `EDGE_BOTH: edge_hit = prev ^ cur;
            default:    edge_hit = 1'b0;
        endcase
    end
endfunction

// highest level now in service
function [1:0] top_level;
    input [3:0] busy;
    begin
        top_level = busy[3] ? 2'd3 : busy[2] ? 2'd2 :
                    busy[1] ? 2'd1 : 2'd0;
    end
endfunction

function wr_hit;
    input       wr;
    input [7:0] addr;
    input [7:0] target;
    begin
        wr_hit = wr && (addr == target);
    end
endfunction

// =====================================================================
// registers
// =====================================================================
reg  [7:0]  src_en0_reg;
reg  [5:0]  src_en1_reg;
reg  [5:0]  src_en2_reg;
reg  [5:0]  src_en3_reg;
reg  [5:0]  level_low_reg;
reg  [5:0]  level_high_reg;
reg  [7:0]  edge_a_low_reg;
reg  [7:0]  edge_a_high_reg;
reg  [5:0]  edge_b_reg;
reg  [7:0]  edge_c_low_reg;
reg  [7:0]  edge_c_high_reg;
reg  [18:0] pin_flag_reg;
reg  [18:0] pin_flag_next;
reg  [18:0] pin_sync1_reg;
reg  [18:0] pin_sync2_reg;
reg  [18:0] pin_prev_reg;
reg  [23:0] pending_reg;
reg  [23:0] pending_next;
reg  [3:0]  in_service_reg;
reg         irq_reg;
reg  [4:0]  latched_src_reg;
integer     i;
integer     j;

wire        global_enable = src_en0_reg[`GLOBAL_EN_BIT];
wire [23:0] src_enable    = {src_en3_reg, src_en2_reg, src_en1_reg[5:0], src_en0_reg[5:0]};
wire [37:0] edge_sel_all  = {edge_c_high_reg, edge_c_low_reg, edge_b_reg,
                             edge_a_high_reg, edge_a_low_reg};

// external pin order inside flags: 0..7, 8, 9, 18, 10..17
wire [18:0] pin_sorted = {ext_pin_i[17:10], ext_pin_i[18], ext_pin_i[9:8], ext_pin_i[7:0]};

// =====================================================================
// external pin edge detection
// =====================================================================
// synchronised level against the level one cycle back
reg  [18:0] pin_edge;
always @* begin
    for (i = 0; i < `NUM_PINS; i = i + 1) begin
        pin_edge[i] = edge_hit(edge_sel_all[2*i +: 2], pin_prev_reg[i],
                               pin_sync2_reg[i]);                    // [R18]
    end
end

always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
        pin_sync1_reg <= 19'h00000;
        pin_sync2_reg <= 19'h00000;
        pin_prev_reg  <= 19'h00000;
    end else begin
        pin_sync1_reg <= pin_sorted;                                 // [R23]
        pin_sync2_reg <= pin_sync1_reg;
        pin_prev_reg  <= pin_sync2_reg;
    end
end

// =====================================================================
// arbitration
// =====================================================================
wire [23:0] eligible = pending_reg & src_enable & {24{global_enable}};  // [R2]

// writes that hold off acceptance in the cycle they are sampled
wire        wr_enable_any = reg_wr_i && reg_addr_i >= `OFF_SRC_EN_0 &&
                            reg_addr_i <= `OFF_SRC_EN_3;
wire        wr_level_any  = wr_hit(reg_wr_i, reg_addr_i, `OFF_LEVEL_LOW) |
                            wr_hit(reg_wr_i, reg_addr_i, `OFF_LEVEL_HIGH);
wire        ctrl_write    = power_control_wr_i | wr_enable_any | wr_level_any;  // [R15]

reg  [4:0]  best_src;
reg  [1:0]  best_level;
reg         best_valid;
reg  [1:0]  cur_level;
reg         cur_busy;
reg  [1:0]  lv;
always @* begin
    best_src   = 5'd0;
    best_level = 2'd0;
    best_valid = 1'b0;
    lv         = 2'd0;
    // scan downward so that an equal level falls to the lower source
    for (j = `NUM_SRC - 1; j >= 0; j = j - 1) begin
        lv = src_level(j[4:0], level_low_reg, level_high_reg);      // [R13]
        if (eligible[j] && (!best_valid || lv >= best_level)) begin // [R9] [R11]
            best_valid = 1'b1;
            best_level = lv;
            best_src   = j[4:0];
        end
    end
    cur_busy  = |in_service_reg;
    cur_level = top_level(in_service_reg);
end

wire can_preempt = best_valid && (!cur_busy || best_level > cur_level);  // [R10]
wire at_boundary = last_cycle_i && !irq_reg;                              // [R5]
wire take        = can_preempt && at_boundary && !ctrl_write;             // [R15]

// =====================================================================
// request latch and vector
// =====================================================================
wire        service  = irq_reg && ack_i;
wire [1:0]  lat_level = src_level(latched_src_reg, level_low_reg, level_high_reg);
// base plus eight per source number
wire [15:0] vec_calc  = `VEC_BASE + ({11'h000, best_src} << `VEC_STEP_SHIFT);  // [R1]

always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
        irq_reg           <= 1'b0;
        latched_src_reg   <= 5'd0;
        vector_o          <= 16'h0000;
        vector_src_o      <= 5'd0;
        vector_low_byte_o <= 8'h00;
    end else if (take) begin
        irq_reg           <= 1'b1;                                   // [R6]
        latched_src_reg   <= best_src;
        vector_o          <= vec_calc;                               // [R1]
        vector_src_o      <= best_src;
        vector_low_byte_o <= vec_calc[7:0];                          // [R7]
    end else if (service) begin
        irq_reg <= 1'b0;                                             // [R7]
    end
end

assign irq_o = irq_reg;

always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
        in_service_reg <= 4'h0;
    end else begin
        // return and entry in one cycle: both land, entry last
        if (return_i)
            in_service_reg[cur_level] <= 1'b0;                       // [R8]
        if (service)
            in_service_reg[lat_level] <= 1'b1;
    end
end

// =====================================================================
// pending flags and pin flags
// =====================================================================
wire        wr_flags_a = wr_hit(reg_wr_i, reg_addr_i, `OFF_EXT_FLAGS_A);
wire        wr_flags_b = wr_hit(reg_wr_i, reg_addr_i, `OFF_EXT_FLAGS_B);
wire        wr_flags_c = wr_hit(reg_wr_i, reg_addr_i, `OFF_EXT_FLAGS_C);
wire        wr_pend_0  = wr_hit(reg_wr_i, reg_addr_i, `OFF_PENDING_0);
wire        wr_pend_1  = wr_hit(reg_wr_i, reg_addr_i, `OFF_PENDING_1);
wire        wr_pend_2  = wr_hit(reg_wr_i, reg_addr_i, `OFF_PENDING_2);
wire        svc_grp_a  = service && (latched_src_reg == `SRC_EXT_A);
wire        svc_grp_b  = service && (latched_src_reg == `SRC_EXT_B);
wire        svc_grp_c  = service && (latched_src_reg == `SRC_EXT_C);
wire        edge_grp_a = |pin_edge[7:0];
wire        edge_grp_b = |pin_edge[10:8];
wire        edge_grp_c = |pin_edge[18:11];

always @* begin
    pin_flag_next = pin_flag_reg;
    if (wr_flags_a)
        pin_flag_next[7:0] = pin_flag_reg[7:0] & reg_wdata_i;
    if (wr_flags_b)
        pin_flag_next[10:8] = pin_flag_reg[10:8] & reg_wdata_i[2:0];
    if (wr_flags_c)
        pin_flag_next[18:11] = pin_flag_reg[18:11] & reg_wdata_i;
    if (svc_grp_a)
        pin_flag_next[7:0] = 8'h00;                                  // [R17]
    if (svc_grp_b)
        pin_flag_next[10:8] = 3'b000;
    if (svc_grp_c)
        pin_flag_next[18:11] = 8'h00;
    // an edge in the clearing cycle still sets its flag
    pin_flag_next = pin_flag_next | pin_edge;                        // [R17]

    pending_next = pending_reg;
    if (service)
        pending_next[latched_src_reg] = 1'b0;                        // [R3]
    if (wr_pend_0)
        pending_next[7:0] = pending_reg[7:0] & reg_wdata_i;          // [R4]
    if (wr_pend_1)
        pending_next[15:8] = pending_reg[15:8] & reg_wdata_i;
    if (wr_pend_2)
        pending_next[23:16] = pending_reg[23:16] & reg_wdata_i;
    pending_next = pending_next | irq_req_i;                         // [R3] [R4]
    pending_next[`SRC_EXT_A] = pending_next[`SRC_EXT_A] | edge_grp_a;   // [R16]
    pending_next[`SRC_EXT_B] = pending_next[`SRC_EXT_B] | edge_grp_b;
    pending_next[`SRC_EXT_C] = pending_next[`SRC_EXT_C] | edge_grp_c;
end

always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
        pin_flag_reg <= 19'h00000;
        pending_reg  <= 24'h000000;
    end else begin
        pin_flag_reg <= pin_flag_next;
        pending_reg  <= pending_next;
    end
end

// ignores global enable and level on purpose
assign wake_release_o = |(pending_reg & src_enable);                 // [R14]

// =====================================================================
// register writes
// =====================================================================
always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
        src_en0_reg     <= `RESET_BYTE;
        src_en1_reg     <= 6'h00;
        src_en2_reg     <= 6'h00;
        src_en3_reg     <= 6'h00;
        level_low_reg   <= 6'h00;                                    // [R13]
        level_high_reg  <= 6'h00;
        edge_a_low_reg  <= `RESET_BYTE;                              // [R18]
        edge_a_high_reg <= `RESET_BYTE;
        edge_b_reg      <= 6'h00;
        edge_c_low_reg  <= `RESET_BYTE;
        edge_c_high_reg <= `RESET_BYTE;
    end else begin
        if (reg_wr_i) begin
            case (reg_addr_i)
                `OFF_SRC_EN_0:    src_en0_reg     <= reg_wdata_i & `EN_MASK_0;
                `OFF_SRC_EN_1:    src_en1_reg     <= reg_wdata_i[5:0];
                `OFF_SRC_EN_2:    src_en2_reg     <= reg_wdata_i[5:0];
                `OFF_SRC_EN_3:    src_en3_reg     <= reg_wdata_i[5:0];
                `OFF_LEVEL_LOW:   level_low_reg   <= reg_wdata_i[5:0];
                `OFF_LEVEL_HIGH:  level_high_reg  <= reg_wdata_i[5:0];
                `OFF_EDGE_A_LOW:  edge_a_low_reg  <= reg_wdata_i;
                `OFF_EDGE_A_HIGH: edge_a_high_reg <= reg_wdata_i;
                `OFF_EDGE_B:      edge_b_reg      <= reg_wdata_i[5:0];
                `OFF_EDGE_C_LOW:  edge_c_low_reg  <= reg_wdata_i;
                `OFF_EDGE_C_HIGH: edge_c_high_reg <= reg_wdata_i;
                default: ;
            endcase
        end
        // hardware global-enable update overrides a same-cycle write
        if (take)
            src_en0_reg[`GLOBAL_EN_BIT] <= 1'b0;                     // [R21]
        else if (return_i)
            src_en0_reg[`GLOBAL_EN_BIT] <= 1'b1;                     // [R21]
    end
end

// =====================================================================
// register reads
// =====================================================================
always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
        reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
        case (reg_addr_i)
            `OFF_EXT_FLAGS_A: reg_rdata_o <= pin_flag_reg[7:0];
            `OFF_EXT_FLAGS_B: reg_rdata_o <= {5'b00000, pin_flag_reg[10:8]};
            `OFF_EXT_FLAGS_C: reg_rdata_o <= pin_flag_reg[18:11];
            `OFF_EDGE_A_LOW:  reg_rdata_o <= edge_a_low_reg;
            `OFF_EDGE_A_HIGH: reg_rdata_o <= edge_a_high_reg;
            `OFF_SRC_EN_0:    reg_rdata_o <= src_en0_reg;
            `OFF_SRC_EN_1:    reg_rdata_o <= {2'b00, src_en1_reg};
            `OFF_SRC_EN_2:    reg_rdata_o <= {2'b00, src_en2_reg};
            `OFF_SRC_EN_3:    reg_rdata_o <= {2'b00, src_en3_reg};
            `OFF_EDGE_B:      reg_rdata_o <= {2'b00, edge_b_reg};
            `OFF_EDGE_C_LOW:  reg_rdata_o <= edge_c_low_reg;
            `OFF_EDGE_C_HIGH: reg_rdata_o <= edge_c_high_reg;
            `OFF_LEVEL_LOW:   reg_rdata_o <= {2'b00, level_low_reg};
            `OFF_LEVEL_HIGH:  reg_rdata_o <= {2'b00, level_high_reg};
            `OFF_PENDING_0:   reg_rdata_o <= pending_reg[7:0];
            `OFF_PENDING_1:   reg_rdata_o <= pending_reg[15:8];
            `OFF_PENDING_2:   reg_rdata_o <= pending_reg[23:16];
            `OFF_IN_SERVICE:  reg_rdata_o <= {4'h0, in_service_reg};
            default:          reg_rdata_o <= 8'h00;
        endcase
    end else begin
        reg_rdata_o <= 8'h00;
    end
end

endmodule

// *** test/int_ctrl_monitor.sv ***
`timescale 1ns/1ps
module int_ctrl_monitor (
    input wire        clk_sys_i,
    input wire        reset_i,
    input wire [7:0]  reg_addr_i,
    input wire        reg_wr_i,
    input wire        reg_rd_i,
    input wire [7:0]  reg_rdata_o,
    input wire        power_control_wr_i,
    input wire        last_cycle_i,
    input wire        ack_i,
    input wire        irq_o,
    input wire [15:0] vector_o,
    input wire [4:0]  vector_src_o,
    input wire [7:0]  vector_low_byte_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    // writes to enable or level registers
    wire ctrl_wr = reg_wr_i && (reg_addr_i[7:2] == 6'h2A || reg_addr_i == 8'hB8
                                || reg_addr_i == 8'hF8);
    property p_vec_map; irq_o |-> vector_o == {8'h00, vector_src_o, 3'b011}; endproperty
    a_vec_map: assert property (p_vec_map) else $error("vector not tied to source");
    property p_low_byte; irq_o |-> vector_low_byte_o == vector_o[7:0]; endproperty
    a_low_byte: assert property (p_low_byte) else $error("low byte mismatch");
    property p_src_range; irq_o |-> vector_src_o < 5'd24; endproperty
    a_src_range: assert property (p_src_range) else $error("source out of range");
    property p_last_cycle; $rose(irq_o) |-> $past(last_cycle_i); endproperty
    a_last_cycle: assert property (p_last_cycle) else $error("accept off last cycle");
    property p_postpone; $rose(irq_o) |-> !$past(ctrl_wr) && !$past(power_control_wr_i);
    endproperty
    a_postpone: assert property (p_postpone) else $error("accept during write");
    property p_hold; irq_o && !ack_i |=> irq_o && $stable(vector_o); endproperty
    a_hold: assert property (p_hold) else $error("request dropped early");
    property p_ack; irq_o && ack_i |=> !irq_o; endproperty
    a_ack: assert property (p_ack) else $error("request kept after ack");
    property p_fall; $fell(irq_o) |-> $past(ack_i); endproperty
    a_fall: assert property (p_fall) else $error("request fell without ack");
    property p_ea_clear; reg_rd_i && reg_addr_i == 8'hA8 && irq_o |=> !reg_rdata_o[7];
    endproperty
    a_ea_clear: assert property (p_ea_clear) else $error("global enable not cleared");
    c_accept: cover property ($rose(irq_o));
    c_ack: cover property (irq_o && ack_i);
    c_blocked: cover property (ctrl_wr && last_cycle_i);
endmodule

// *** test/cpu_core_model.sv ***
`timescale 1ns/1ps
module cpu_core_model (
    input  wire clk_sys_i,
    input  wire reset_i,
    input  wire irq_i,
    input  wire slow_i,
    input  wire ret_req_i,
    output reg  last_cycle_o,
    output reg  ack_o,
    output reg  return_o
);
    reg [1:0] phase_reg;
    reg [2:0] wait_reg;
    // three-cycle instructions; slow mode delays the ack
    always @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            phase_reg <= 2'd0;
            wait_reg <= 3'd0;
            last_cycle_o <= 1'b0;
            ack_o <= 1'b0;
            return_o <= 1'b0;
        end else begin
            phase_reg <= (phase_reg == 2'd2) ? 2'd0 : phase_reg + 2'd1;
            last_cycle_o <= (phase_reg == 2'd1);
            wait_reg <= irq_i ? wait_reg + 3'd1 : 3'd0;
            ack_o <= irq_i && !ack_o && (!slow_i || wait_reg == 3'd4);
            return_o <= ret_req_i;
        end
    end
endmodule

// *** test/vectored_priority_interrupt_controller_tb.sv ***
`timescale 1ns/1ps
module vectored_priority_interrupt_controller_tb;
    // ==========================================
    // signals
    reg         clk_sys_i, reset_i, reg_wr_i, reg_rd_i, power_control_wr_i, slow, ret_req;
    reg  [7:0]  reg_addr_i, reg_wdata_i;
    reg  [23:0] irq_req_i;
    reg  [18:0] ext_pin_i;
    wire [7:0]  reg_rdata_o, vector_low_byte_o;
    wire        last_cycle_i, ack_i, return_i, irq_o, wake_release_o;
    wire [15:0] vector_o;
    wire [4:0]  vector_src_o;
    integer     failures, samples_checked, cycles, i;
    reg  [111:0] offs;
    vectored_priority_interrupt_controller dut (.clk_sys_i, .reset_i, .reg_addr_i,
        .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_req_i, .ext_pin_i,
        .power_control_wr_i, .last_cycle_i, .ack_i, .return_i, .irq_o, .vector_o,
        .vector_src_o, .vector_low_byte_o, .wake_release_o);
    cpu_core_model cpu (.clk_sys_i, .reset_i, .irq_i(irq_o), .slow_i(slow),
        .ret_req_i(ret_req), .last_cycle_o(last_cycle_i), .ack_o(ack_i), .return_o(return_i));
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            failures = failures + 1;
            stop_test;
        end
    end
    // ==========================================
    // tasks
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", samples_checked, failures);
            if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    task chk(input [8*10:1] name, input [15:0] exp, input [15:0] got);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("wrong value %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task idle(input integer n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge clk_sys_i);
            reg_wr_i <= 1'b1; reg_addr_i <= a; reg_wdata_i <= d;
            @(posedge clk_sys_i);
            reg_wr_i <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [7:0] exp);
        begin
            @(posedge clk_sys_i);
            reg_rd_i <= 1'b1; reg_addr_i <= a;
            @(posedge clk_sys_i);
            reg_rd_i <= 1'b0;
            #1 chk("read data", {8'h00, exp}, {8'h00, reg_rdata_o});
        end
    endtask
    task pulse(input [23:0] m);
        begin
            @(posedge clk_sys_i) irq_req_i <= m;
            @(posedge clk_sys_i) irq_req_i <= 24'h0;
        end
    endtask
    task serve(input [4:0] s);
        integer k;
        begin
            k = 0;
            while (irq_o !== 1'b1 && k < 60) begin @(posedge clk_sys_i); #1 k = k + 1; end
            chk("request", 16'h1, {15'h0, irq_o});
            chk("vector", {8'h00, s, 3'b011}, vector_o);
            chk("source", {11'h0, s}, {11'h0, vector_src_o});
            chk("low byte", {8'h00, s, 3'b011}, {8'h00, vector_low_byte_o});
            rd(8'hA8, 8'h3F);
            while (irq_o === 1'b1 && k < 120) begin @(posedge clk_sys_i); #1 k = k + 1; end
        end
    endtask
    task ret;
        begin
            @(posedge clk_sys_i) ret_req <= 1'b1;
            @(posedge clk_sys_i) ret_req <= 1'b0;
            idle(2);
        end
    endtask
    task quiet;
        begin
            idle(12);
            #1 chk("no request", 16'h0, {15'h0, irq_o});
        end
    endtask
    // ==========================================
    // tests
    initial begin
        reset_i = 1'b1; reg_wr_i = 1'b0; reg_rd_i = 1'b0; reg_addr_i = 8'h00;
        reg_wdata_i = 8'h00; irq_req_i = 24'h0; ext_pin_i = 19'h0; power_control_wr_i = 1'b0;
        slow = 1'b0; ret_req = 1'b0; failures = 0; samples_checked = 0; cycles = 0;
        offs = {8'hA3, 8'hA4, 8'hA5, 8'hA6, 8'hA7, 8'hA8, 8'hA9, 8'hAA, 8'hAB, 8'hAD,
                8'hAE, 8'hAF, 8'hB8, 8'hF8};
        idle(3);
        reset_i <= 1'b0;
        for (i = 0; i < 14; i = i + 1) rd(offs[i*8 +: 8], 8'h00);
        wr(8'hAC, 8'hFF); rd(8'hAC, 8'h00);
        wr(8'hA8, 8'hFF); rd(8'hA8, 8'hBF);
        wr(8'hA9, 8'h3F); wr(8'hAA, 8'h3F); wr(8'hAB, 8'h3F);
        $display("test done: registers");
        for (i = 0; i < 24; i = i + 1) begin
            slow <= i[0];
            pulse(24'h1 << i);
            serve(i[4:0]);
            rd(8'hA8, 8'h3F);
            ret;
            rd(8'hA8, 8'hBF);
        end
        $display("test done: vectors");
        wr(8'hA8, 8'h3F); pulse(24'h2); quiet;
        rd(8'hC0, 8'h02);
        chk("wake", 16'h1, {15'h0, wake_release_o});
        wr(8'hC0, 8'h00); rd(8'hC0, 8'h00);
        pulse(24'h2);
        @(posedge clk_sys_i) power_control_wr_i <= 1'b1;
        wr(8'hA8, 8'hBF); quiet;
        @(posedge clk_sys_i) power_control_wr_i <= 1'b0;
        serve(5'd1); ret;
        $display("test done: masking");
        wr(8'hB8, 8'h05); wr(8'hF8, 8'h06);
        pulse(24'h000081); serve(5'd7);
        wr(8'hA8, 8'hBF); quiet;
        pulse(24'h000004); serve(5'd2);
        ret; quiet;
        ret; serve(5'd0); ret;
        wr(8'hB8, 8'h00); wr(8'hF8, 8'h00);
        pulse(24'h400014); serve(5'd2); quiet;
        ret; serve(5'd4); ret; serve(5'd22); ret;
        $display("test done: priority");
        wr(8'hA8, 8'h3F); wr(8'hA6, 8'h39);
        @(posedge clk_sys_i) ext_pin_i[3:0] <= 4'hF;
        idle(6); rd(8'hA3, 8'h05);
        @(posedge clk_sys_i) ext_pin_i[3:0] <= 4'h0;
        idle(6); rd(8'hA3, 8'h07);
        wr(8'hA3, 8'hFE); rd(8'hA3, 8'h06);
        wr(8'hAD, 8'h30); wr(8'hAF, 8'h40);
        @(posedge clk_sys_i) ext_pin_i[18:17] <= 2'b11;
        idle(6); rd(8'hA4, 8'h04); rd(8'hA5, 8'h80);
        wr(8'hA8, 8'hBF);
        serve(5'd5); rd(8'hA3, 8'h00); ret;
        serve(5'd16); rd(8'hA4, 8'h00); ret;
        serve(5'd23); rd(8'hA5, 8'h00); ret;
        $display("test done: pins");
        stop_test;
    end
endmodule
bind vectored_priority_interrupt_controller int_ctrl_monitor u_mon (.clk_sys_i, .reset_i,
    .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .power_control_wr_i, .last_cycle_i,
    .ack_i, .irq_o, .vector_o, .vector_src_o, .vector_low_byte_o);
